// File: logic/cpa_pkg.sv
package cpa_pkg;

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam int          ADDR_W    = 22;
  localparam logic [21:0] ID_LO     = 22'h200000;
  localparam logic [21:0] ID_HI     = 22'h200007;
  localparam logic [21:0] CFG_LO    = 22'h300008;
  localparam logic [21:0] CFG_HI    = 22'h30000f;
  localparam logic [21:0] DEVID_LO  = 22'h3ffffe;
  localparam logic [21:0] DEVID_HI  = 22'h3fffff;

  // ------------------------------------------------------------
  // configuration byte offsets and fields
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_CP_LO = 4'h8;
  localparam logic [3:0] OFS_CP_HI = 4'h9;
  localparam logic [3:0] OFS_WP_LO = 4'ha;
  localparam logic [3:0] OFS_WP_HI = 4'hb;
  localparam logic [3:0] OFS_TR_LO = 4'hc;
  localparam logic [3:0] OFS_TR_HI = 4'hd;
  localparam logic [3:0] OFS_MISC  = 4'he;
  localparam logic [3:0] OFS_STAT  = 4'hf;
  localparam int         CFG_N     = 7;
  localparam int         B_EE      = 7;
  localparam int         B_BOOT    = 6;
  localparam int         B_CFGWP   = 5;
  localparam int         B_DBG     = 0;
  localparam int         B_LVP     = 2;
  // implemented bits per byte; erased value is all implemented bits at one
  localparam logic [CFG_N-1:0][7:0] CFG_MASK =
    {8'h05, 8'h40, 8'h03, 8'he0, 8'h03, 8'hc0, 8'h03};

  // ------------------------------------------------------------
  // debugger reservations
  // ------------------------------------------------------------
  localparam logic [1:0] DBG_STACK_LEVELS = 2'h2;
  localparam logic [9:0] DBG_PROG_BYTES   = 10'h200;
  localparam logic [3:0] DBG_DATA_BYTES   = 4'ha;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_HV  = 2'b01,
    MODE_SS  = 2'b10
  } cpa_mode_type;

  typedef enum logic [1:0] {
    ER_NONE  = 2'b00,
    ER_CHIP  = 2'b01,
    ER_BLOCK = 2'b10,
    ER_ROW   = 2'b11
  } cpa_erase_type;

  typedef logic [CFG_N-1:0][7:0] cpa_cfg_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        eeprom;
    logic [21:0] addr;
    logic [21:0] pc;
    logic [7:0]  wdata;
  } cpa_tbl_req_type;

  typedef struct packed {
    logic          valid;
    logic          write;
    logic          eeprom;
    cpa_erase_type erase;
    logic [21:0]   addr;
    logic [7:0]    wdata;
  } cpa_prg_req_type;

  typedef struct packed {
    logic       done;
    logic       granted;
    logic [7:0] rdata;
  } cpa_rsp_type;

  typedef struct packed {
    logic       enable;
    logic       pinsReserved;
    logic [1:0] stackLevels;
    logic [9:0] progBytes;
    logic [3:0] dataBytes;
  } cpa_dbg_type;

  typedef struct packed {
    logic         pgmMeta;
    logic         pgmSync;
    logic         hvMeta;
    logic         hvSync;
    cpa_mode_type mode;
    cpa_cfg_type  cfg;
    cpa_rsp_type  tblRsp;
    cpa_rsp_type  prgRsp;
    logic [7:0]   regRdata;
    logic         entryIsIo;
    cpa_dbg_type  dbg;
  } cpa_st_type;

endpackage

// File: logic/cpa_access_check.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
// How it works
// - block code protect only blocks programmer
// - write protect zero rejects table writes
// - same-block table read sees real data
// - foreign table read refused when read protect is zero, returns zeros
// - protection bits only go one to zero
// - only programmer erase or reset sets protection bits to one
// - eeprom code protect blocks programmer access
// - eeprom write protect blocks all writes
// - cpu may always read eeprom
// - config write protect changes only externally
// - eight id locations read and writable
// - id locations readable under protection
// - part id and config words reachable
// - debug bit zero reserves debugger resources
// - entry pin high enters single-supply mode
// - high voltage on reset always enters
// - erased part has single-supply enabled
// - single-supply off frees entry pin
// - single-supply bit changes only under high voltage
// - protected memory needs block erase
// - each block has own three bits
module cpa_access_check
  import cpa_pkg::*;
#(
  parameter logic [21:0] BOOT_END = 22'h0007ff,
  parameter logic [21:0] BLK0_END = 22'h000fff,
  parameter logic [21:0] BLK1_END = 22'h001fff,
  parameter logic [15:0] DEV_ID   = 16'h5a00   // arbitrary value
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire cpa_pkg::cpa_tbl_req_type tblReq,
  input  wire logic [7:0]               tblMemRdata,
  output cpa_pkg::cpa_rsp_type          tblRsp,
  input  wire cpa_pkg::cpa_prg_req_type prgReq,
  input  wire logic [7:0]               prgMemRdata,
  output cpa_pkg::cpa_rsp_type          prgRsp,
  input  wire logic [3:0]               regAddr,
  input  wire logic [7:0]               regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [7:0]                    regRdata,
  input  wire logic                     progEntryPin,
  input  wire logic                     highVoltPin,
  output cpa_pkg::cpa_mode_type         progMode,
  output logic                          entryPinIsIo,
  output cpa_pkg::cpa_dbg_type          dbg
);
  import cpa_pkg::*;

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (!(BOOT_END < BLK0_END && BLK0_END < BLK1_END && BLK1_END < ID_LO)) begin : g_chk
    $error("block bounds must ascend below the id range");
  end

  localparam logic [1:0] BLK_BOOT = 2'd0;
  localparam logic [1:0] BLK_0    = 2'd1;
  localparam logic [1:0] BLK_1    = 2'd2;
  localparam logic [1:0] BLK_NONE = 2'd3;

  cpa_st_type s;
  cpa_st_type n;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] blockOf(input logic [21:0] a);
    if (a <= BOOT_END) return BLK_BOOT;
    else if (a <= BLK0_END) return BLK_0;
    else if (a <= BLK1_END) return BLK_1;
    else return BLK_NONE;
  endfunction

  // lo is the byte holding blocks 0 and 1, the next one holds boot
  function automatic logic protBit(input cpa_cfg_type c, input logic [3:0] lo,
                                   input logic [1:0] b);
    logic [2:0] i;
    i = lo[2:0];
    unique case (b)
      BLK_BOOT: return c[i + 3'd1][B_BOOT];
      BLK_0:    return c[i][0];
      BLK_1:    return c[i][1];
      default:  return 1'b1;
    endcase
  endfunction

  function automatic cpa_cfg_type setBlock(input cpa_cfg_type c, input logic [1:0] b);
    cpa_cfg_type r;
    r = c;
    unique case (b)
      BLK_BOOT: begin
        r[1][B_BOOT] = 1'b1;
        r[3][B_BOOT] = 1'b1;
        r[5][B_BOOT] = 1'b1;
      end
      BLK_0: begin
        r[0][0] = 1'b1;
        r[2][0] = 1'b1;
        r[4][0] = 1'b1;
      end
      BLK_1: begin
        r[0][1] = 1'b1;
        r[2][1] = 1'b1;
        r[4][1] = 1'b1;
      end
      default: begin
        r[1][B_EE] = 1'b1;
        r[3][B_EE] = 1'b1;
      end
    endcase
    return r;
  endfunction

  function automatic cpa_cfg_type cfgWrite(input cpa_cfg_type c, input logic [3:0] ofs,
                                           input logic [7:0] v, input logic ext,
                                           input logic hv);
    cpa_cfg_type r;
    logic [7:0]  keep;
    logic [7:0]  nv;
    logic [2:0]  i;
    r = c;
    i = ofs[2:0];
    keep = 8'h00;
    nv = 8'h00;
    if (ofs == OFS_WP_HI && !ext) keep[B_CFGWP] = 1'b1;
    if (ofs == OFS_MISC && !hv) keep[B_LVP] = 1'b1;
    if (ofs >= OFS_CP_LO && ofs <= OFS_MISC && (ext || c[3][B_CFGWP])) begin
      nv = (ofs == OFS_MISC) ? v : (c[i] & v);
      r[i] = ((nv & ~keep) | (c[i] & keep)) & CFG_MASK[i];
    end
    return r;
  endfunction

  function automatic logic [7:0] cfgRead(input cpa_st_type st, input logic [3:0] ofs);
    if (ofs == OFS_STAT) return {5'h00, st.mode, st.dbg.enable};
    else if (ofs >= OFS_CP_LO) return st.cfg[ofs[2:0]];
    else return 8'h00;
  endfunction

  function automatic logic [7:0] devIdRead(input logic [21:0] a);
    return (a == DEVID_LO) ? DEV_ID[7:0] : DEV_ID[15:8];
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] blkA;
    logic [1:0] blkP;
    logic       ok;
    logic [7:0] dat;
    logic       hvNow;
    blkA = BLK_NONE;
    blkP = BLK_NONE;
    ok = 1'b0;
    dat = 8'h00;
    n = s;
    n.pgmMeta = progEntryPin;
    n.pgmSync = s.pgmMeta;
    n.hvMeta = highVoltPin;
    n.hvSync = s.hvMeta;
    hvNow = (s.mode == MODE_HV);

    if (s.hvSync) n.mode = MODE_HV;
    else if (s.cfg[6][B_LVP] && s.pgmSync) n.mode = MODE_SS;
    else n.mode = MODE_RUN;

    // cpu table and eeprom path
    n.tblRsp = '0;
    if (tblReq.valid) begin
      blkA = blockOf(tblReq.addr);
      blkP = blockOf(tblReq.pc);
      dat = tblMemRdata;
      if (tblReq.eeprom) begin
        ok = !tblReq.write || s.cfg[3][B_EE];
      end else if (blkA != BLK_NONE) begin
        if (tblReq.write) ok = protBit(s.cfg, OFS_WP_LO, blkA);
        else ok = protBit(s.cfg, OFS_TR_LO, blkA) || (blkA == blkP);
      end else if (tblReq.addr >= ID_LO && tblReq.addr <= ID_HI) begin
        ok = 1'b1;
      end else if (tblReq.addr >= CFG_LO && tblReq.addr <= CFG_HI) begin
        ok = !tblReq.write || s.cfg[3][B_CFGWP];
        dat = cfgRead(s, tblReq.addr[3:0]);
        if (tblReq.write) n.cfg = cfgWrite(n.cfg, tblReq.addr[3:0], tblReq.wdata, 1'b0, hvNow);
      end else if (tblReq.addr >= DEVID_LO && !tblReq.write) begin
        ok = 1'b1;
        dat = devIdRead(tblReq.addr);
      end else begin
        ok = !tblReq.write;
        dat = 8'h00;
      end
      n.tblRsp.done = 1'b1;
      n.tblRsp.granted = ok;
      n.tblRsp.rdata = (ok && !tblReq.write) ? dat : 8'h00;
    end

    // software register port
    n.regRdata = 8'h00;
    if (regWr) n.cfg = cfgWrite(n.cfg, regAddr, regWdata, 1'b0, hvNow);
    if (regRd) n.regRdata = cfgRead(s, regAddr);

    // external programmer path, live only in a programming mode
    n.prgRsp = '0;
    ok = 1'b0;
    dat = prgMemRdata;
    if (prgReq.valid) begin
      blkA = blockOf(prgReq.addr);
      if (s.mode == MODE_RUN) begin
        ok = 1'b0;
      end else if (prgReq.erase == ER_CHIP) begin
        ok = 1'b1;
        n.cfg = CFG_MASK;
      end else if (prgReq.erase == ER_BLOCK) begin
        ok = 1'b1;
        n.cfg = setBlock(n.cfg, prgReq.eeprom ? BLK_NONE : blkA);
      end else if (prgReq.erase == ER_ROW) begin
        ok = blkA != BLK_NONE && protBit(s.cfg, OFS_CP_LO, blkA);
      end else if (prgReq.eeprom) begin
        ok = s.cfg[1][B_EE] && (!prgReq.write || s.cfg[3][B_EE]);
      end else if (blkA != BLK_NONE) begin
        ok = protBit(s.cfg, OFS_CP_LO, blkA);
      end else if (prgReq.addr >= ID_LO && prgReq.addr <= ID_HI) begin
        ok = 1'b1;
      end else if (prgReq.addr >= CFG_LO && prgReq.addr <= CFG_HI) begin
        ok = 1'b1;
        dat = cfgRead(s, prgReq.addr[3:0]);
        if (prgReq.write) n.cfg = cfgWrite(n.cfg, prgReq.addr[3:0], prgReq.wdata, 1'b1, hvNow);
      end else if (prgReq.addr >= DEVID_LO && !prgReq.write) begin
        ok = 1'b1;
        dat = devIdRead(prgReq.addr);
      end else begin
        ok = !prgReq.write;
        dat = 8'h00;
      end
      n.prgRsp.done = 1'b1;
      n.prgRsp.granted = ok;
      n.prgRsp.rdata = (ok && !prgReq.write && prgReq.erase == ER_NONE) ? dat : 8'h00;
    end

    n.entryIsIo = !s.cfg[6][B_LVP];
    n.dbg.enable = !s.cfg[6][B_DBG];
    n.dbg.pinsReserved = !s.cfg[6][B_DBG];
    n.dbg.stackLevels = s.cfg[6][B_DBG] ? 2'h0 : DBG_STACK_LEVELS;
    n.dbg.progBytes = s.cfg[6][B_DBG] ? 10'h000 : DBG_PROG_BYTES;
    n.dbg.dataBytes = s.cfg[6][B_DBG] ? 4'h0 : DBG_DATA_BYTES;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.mode <= MODE_RUN;
      s.cfg <= CFG_MASK;
      s.dbg.enable <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign tblRsp = s.tblRsp;
  assign prgRsp = s.prgRsp;
  assign regRdata = s.regRdata;
  assign progMode = s.mode;
  assign entryPinIsIo = s.entryIsIo;
  assign dbg = s.dbg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_wp;
    tblReq.valid && tblReq.write && !tblReq.eeprom && blockOf(tblReq.addr) != BLK_NONE
      && !protBit(s.cfg, OFS_WP_LO, blockOf(tblReq.addr)) |=> !tblRsp.granted;
  endproperty
  a_wp: assert property (p_wp) else $error("protected table write granted");

  property p_trIn;
    tblReq.valid && !tblReq.write && !tblReq.eeprom && blockOf(tblReq.addr) != BLK_NONE
      && blockOf(tblReq.addr) == blockOf(tblReq.pc) |=> tblRsp.granted;
  endproperty
  a_trIn: assert property (p_trIn) else $error("same block read refused");

  property p_trOut;
    tblReq.valid && !tblReq.write && !tblReq.eeprom && blockOf(tblReq.addr) != BLK_NONE
      && blockOf(tblReq.addr) != blockOf(tblReq.pc)
      && !protBit(s.cfg, OFS_TR_LO, blockOf(tblReq.addr))
      |=> !tblRsp.granted && tblRsp.rdata == 8'h00;
  endproperty
  a_trOut: assert property (p_trOut) else $error("foreign read not zeroed");

  property p_oneWay;
    !s.cfg[0][0] && !(prgReq.valid && prgReq.erase != ER_NONE) |=> !s.cfg[0][0];
  endproperty
  a_oneWay: assert property (p_oneWay) else $error("protection bit set without erase");

  property p_eeRead;
    tblReq.valid && tblReq.eeprom && !tblReq.write |=> tblRsp.done && tblRsp.granted;
  endproperty
  a_eeRead: assert property (p_eeRead) else $error("cpu eeprom read refused");

  property p_eeWrite;
    prgReq.valid && prgReq.eeprom && prgReq.write && prgReq.erase == ER_NONE
      && !s.cfg[3][B_EE] |=> !prgRsp.granted;
  endproperty
  a_eeWrite: assert property (p_eeWrite) else $error("protected eeprom write granted");

  property p_eeExt;
    prgReq.valid && prgReq.eeprom && prgReq.erase == ER_NONE && !s.cfg[1][B_EE]
      |=> prgRsp.done && !prgRsp.granted;
  endproperty
  a_eeExt: assert property (p_eeExt) else $error("external eeprom access granted");

  property p_cfgWp;
    regWr && regAddr == OFS_WP_HI && !prgReq.valid |=> $stable(s.cfg[3][B_CFGWP]);
  endproperty
  a_cfgWp: assert property (p_cfgWp) else $error("config protect changed by software");

  property p_row;
    prgReq.valid && prgReq.erase == ER_ROW && blockOf(prgReq.addr) != BLK_NONE
      && !protBit(s.cfg, OFS_CP_LO, blockOf(prgReq.addr)) |=> !prgRsp.granted;
  endproperty
  a_row: assert property (p_row) else $error("row erase of protected block granted");

  sequence s_hvHeld;
    highVoltPin [*3];
  endsequence
  property p_hv;
    s_hvHeld |=> progMode == MODE_HV;
  endproperty
  a_hv: assert property (p_hv) else $error("high voltage entry missed");

  property p_dbgOn;
    !s.cfg[6][B_DBG] |=> dbg.enable && dbg.pinsReserved && dbg.stackLevels == DBG_STACK_LEVELS
      && dbg.progBytes == DBG_PROG_BYTES && dbg.dataBytes == DBG_DATA_BYTES;
  endproperty
  a_dbgOn: assert property (p_dbgOn) else $error("debugger resources not reserved");

  property p_entryDedicated;
    s.cfg[6][B_LVP] |=> !entryPinIsIo;
  endproperty
  a_entryDedicated: assert property (p_entryDedicated) else $error("entry pin freed");

  property p_entryFree;
    !s.cfg[6][B_LVP] |=> entryPinIsIo;
  endproperty
  a_entryFree: assert property (p_entryFree) else $error("entry pin not freed");

  property p_lvpHold;
    s.mode != MODE_HV |=> $stable(s.cfg[6][B_LVP]);
  endproperty
  a_lvpHold: assert property (p_lvpHold) else $error("single-supply bit changed");

  property p_devId;
    tblReq.valid && !tblReq.write && tblReq.addr == DEVID_LO
      |=> tblRsp.granted && tblRsp.rdata == DEV_ID[7:0];
  endproperty
  a_devId: assert property (p_devId) else $error("part id read wrong");

  property p_idTbl;
    tblReq.valid && !tblReq.eeprom && tblReq.addr >= ID_LO && tblReq.addr <= ID_HI
      |=> tblRsp.done && tblRsp.granted;
  endproperty
  a_idTbl: assert property (p_idTbl) else $error("id location access refused");

  property p_idPrg;
    prgReq.valid && s.mode != MODE_RUN && prgReq.erase == ER_NONE && !prgReq.eeprom
      && prgReq.addr >= ID_LO && prgReq.addr <= ID_HI |=> prgRsp.granted;
  endproperty
  a_idPrg: assert property (p_idPrg) else $error("id location refused to programmer");

  property p_chipErase;
    prgReq.valid && prgReq.erase == ER_CHIP && s.mode != MODE_RUN |=> s.cfg == CFG_MASK;
  endproperty
  a_chipErase: assert property (p_chipErase) else $error("chip erase left bits cleared");

  property p_runRefuse;
    prgReq.valid && s.mode == MODE_RUN |=> prgRsp.done && !prgRsp.granted;
  endproperty
  a_runRefuse: assert property (p_runRefuse) else $error("programmer served in run mode");

endmodule

// File: verification/cpa_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// memory array seen by the table path and the programmer
// ------------------------------------------------------------
module cpa_mem_model (
  input  wire logic [21:0] tblAddr,
  input  wire logic [21:0] prgAddr,
  output logic [7:0]       tblRdata,
  output logic [7:0]       prgRdata
);
  // address-derived pattern, so a zeroed refusal matches real data only where the low address byte is 8'h5c
  assign tblRdata = tblAddr[7:0] ^ 8'h5c;
  assign prgRdata = prgAddr[7:0] ^ 8'h5c;
endmodule

// File: verification/cpa_access_check_tb_top.sv
`timescale 1ns/1ps
module cpa_access_check_tb_top;
  import cpa_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [15:0] DEVID = 16'h3c96; // arbitrary value
  logic            clk          = 1'b0;
  logic            rst          = 1'b1;
  cpa_tbl_req_type tblReq       = '0;
  cpa_prg_req_type prgReq       = '0;
  logic [3:0]      regAddr      = 4'h0;
  logic [7:0]      regWdata     = 8'h00;
  logic            regWr        = 1'b0;
  logic            regRd        = 1'b0;
  logic            progEntryPin = 1'b0;
  logic            highVoltPin  = 1'b0;
  cpa_rsp_type     tblRsp;
  cpa_rsp_type     prgRsp;
  logic [7:0]      tblMemRdata;
  logic [7:0]      prgMemRdata;
  logic [7:0]      regRdata;
  cpa_mode_type    progMode;
  logic            entryPinIsIo;
  cpa_dbg_type     dbg;
  int              err_total    = 0;
  int              compares     = 0;

  always #4 clk = ~clk;

  cpa_access_check #(.DEV_ID(DEVID)) cpa_access_check_inst (
    .clk(clk), .rst(rst), .tblReq(tblReq), .tblMemRdata(tblMemRdata),
    .tblRsp(tblRsp), .prgReq(prgReq), .prgMemRdata(prgMemRdata), .prgRsp(prgRsp),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .progEntryPin(progEntryPin), .highVoltPin(highVoltPin),
    .progMode(progMode), .entryPinIsIo(entryPinIsIo), .dbg(dbg)
  );

  cpa_mem_model cpa_mem_model_inst (
    .tblAddr(tblReq.addr), .prgAddr(prgReq.addr),
    .tblRdata(tblMemRdata), .prgRdata(prgMemRdata)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] m(input logic [21:0] a);
    return a[7:0] ^ 8'h5c;
  endfunction

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic regW(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  task automatic regR(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    chk("regRdata", 32'(e), 32'(regRdata));
  endtask

  task automatic tbl(input logic w, input logic ee, input logic [21:0] a,
                     input logic [21:0] pc, input logic [7:0] wd,
                     input logic g, input logic [7:0] d);
    @(posedge clk);
    tblReq <= '{1'b1, w, ee, a, pc, wd};
    @(posedge clk);
    tblReq.valid <= 1'b0;
    #1;
    chk("tblRsp", 32'({1'b1, g, d}), 32'(tblRsp));
  endtask

  task automatic prg(input logic w, input logic ee, input cpa_erase_type er,
                     input logic [21:0] a, input logic g, input logic [7:0] d);
    @(posedge clk);
    prgReq <= '{1'b1, w, ee, er, a, 8'h5a};
    @(posedge clk);
    prgReq.valid <= 1'b0;
    #1;
    chk("prgRsp", 32'({1'b1, g, d}), 32'(prgRsp));
  endtask

  task automatic waitMode(input cpa_mode_type md);
    for (int i = 0; i < 20 && progMode !== md; i++) @(posedge clk);
    #1;
    chk("progMode", 32'(md), 32'(progMode));
    if (progMode !== md) end_sim();
  endtask

  initial begin
    #400000;
    err_total++;
    end_sim();
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("progMode", 32'h0, 32'(progMode));
    chk("dbg", 32'h0, 32'(dbg));
    regR(OFS_MISC, 8'h05);
    regR(OFS_CP_HI, 8'hc0);
    $display("test reset done");
    regW(OFS_TR_LO, 8'hfe);
    tbl(1'b0, 1'b0, 22'h000900, 22'h000a00, 8'h00, 1'b1, m(22'h900));
    tbl(1'b0, 1'b0, 22'h000900, 22'h000100, 8'h00, 1'b0, 8'h00);
    tbl(1'b0, 1'b0, 22'h001100, 22'h000100, 8'h00, 1'b1, m(22'h100));
    regW(OFS_TR_LO, 8'hff);
    regR(OFS_TR_LO, 8'h02);
    regW(OFS_WP_LO, 8'hfe);
    tbl(1'b1, 1'b0, 22'h000900, 22'h000900, 8'h11, 1'b0, 8'h00);
    tbl(1'b1, 1'b0, 22'h001100, 22'h000900, 8'h11, 1'b1, 8'h00);
    regW(OFS_CP_LO, 8'hfe);
    tbl(1'b0, 1'b0, 22'h000900, 22'h000900, 8'h00, 1'b1, m(22'h900));
    prg(1'b0, 1'b0, ER_CHIP, 22'h0, 1'b0, 8'h00);
    regR(OFS_CP_LO, 8'h02);
    $display("test user blocks done");
    regW(OFS_WP_HI, 8'h7f);
    regR(OFS_WP_HI, 8'h60);
    tbl(1'b1, 1'b1, 22'h000010, 22'h0, 8'h33, 1'b0, 8'h00);
    tbl(1'b0, 1'b1, 22'h000010, 22'h0, 8'h00, 1'b1, m(22'h10));
    regW(OFS_WP_HI, 8'h00);
    regR(OFS_WP_HI, 8'h20);
    tbl(1'b1, 1'b0, 22'h200003, 22'h000900, 8'h44, 1'b1, 8'h00);
    tbl(1'b0, 1'b0, ID_HI, 22'h001100, 8'h00, 1'b1, m(ID_HI));
    tbl(1'b0, 1'b0, DEVID_LO, 22'h0, 8'h00, 1'b1, DEVID[7:0]);
    tbl(1'b0, 1'b0, DEVID_HI, 22'h0, 8'h00, 1'b1, DEVID[15:8]);
    tbl(1'b0, 1'b0, CFG_LO, 22'h0, 8'h00, 1'b1, 8'h02);
    $display("test eeprom and id done");
    regW(OFS_MISC, 8'h00);
    regR(OFS_MISC, 8'h04);
    chk("dbg", 32'({1'b1, 1'b1, 2'h2, 10'h200, 4'ha}), 32'(dbg));
    regR(OFS_STAT, 8'h01);
    $display("test debug done");
    @(posedge clk);
    highVoltPin <= 1'b1;
    waitMode(MODE_HV);
    regR(OFS_STAT, 8'h03);
    prg(1'b0, 1'b0, ER_NONE, 22'h000900, 1'b0, 8'h00);
    prg(1'b0, 1'b0, ER_NONE, 22'h001100, 1'b1, m(22'h100));
    prg(1'b0, 1'b1, ER_NONE, 22'h000020, 1'b1, m(22'h20));
    prg(1'b1, 1'b1, ER_NONE, 22'h000020, 1'b0, 8'h00);
    prg(1'b0, 1'b0, ER_ROW, 22'h000900, 1'b0, 8'h00);
    prg(1'b0, 1'b0, ER_ROW, 22'h001100, 1'b1, 8'h00);
    prg(1'b0, 1'b0, ER_BLOCK, 22'h000900, 1'b1, 8'h00);
    regR(OFS_CP_LO, 8'h03);
    regR(OFS_TR_LO, 8'h03);
    regW(OFS_CP_HI, 8'h40);
    prg(1'b0, 1'b1, ER_NONE, 22'h000020, 1'b0, 8'h00);
    prg(1'b0, 1'b0, ER_NONE, ID_LO, 1'b1, m(ID_LO));
    regW(OFS_MISC, 8'h00);
    regR(OFS_MISC, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("entryPinIsIo", 32'h1, 32'(entryPinIsIo));
    prg(1'b0, 1'b0, ER_CHIP, 22'h0, 1'b1, 8'h00);
    regR(OFS_MISC, 8'h05);
    regR(OFS_CP_HI, 8'hc0);
    chk("dbg", 32'h0, 32'(dbg));
    chk("entryPinIsIo", 32'h0, 32'(entryPinIsIo));
    $display("test programmer done");
    @(posedge clk);
    highVoltPin  <= 1'b0;
    progEntryPin <= 1'b1;
    waitMode(MODE_SS);
    @(posedge clk);
    progEntryPin <= 1'b0;
    waitMode(MODE_RUN);
    $display("test entry done");
    end_sim();
  end
endmodule
